// ===== design/abk_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "abk_cfg.svh"
module abk_bank (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire abk_pkg::abk_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output abk_pkg::abk_word_t reg_rdata,
  input wire logic [55:0] sample_in,
  input wire abk_pkg::abk_lane_vec_t pattern_on,
  output logic [55:0] lane_out,
  output abk_pkg::abk_lane_vec_t digital_off,
  output abk_pkg::abk_lane_vec_t line_off,
  output abk_pkg::abk_lane_vec_t analog_off,
  output abk_pkg::abk_skew_t bitclock_skew_setting,
  output logic [7:0] bitclock_skew_ps_mag,
  output logic bitclock_skew_neg
);
  import abk_pkg::*;
  typedef struct packed {
    abk_word_t pwr_reg;
    abk_skew_t dly_reg;
    abk_word_t rdata_reg;
    logic [7:0] mag_reg;
    logic neg_reg;
  } abk_st_t;
  abk_st_t st_reg;
  abk_st_t st_next;
  abk_skew_t dly_w;
  logic [3:0] abs_w;
  always_comb begin
    st_next = st_reg;
    dly_w = st_reg.dly_reg;
    abs_w = '0;
    if (reg_wr && reg_addr == `ABK_ADDR_PWR) begin
      st_next.pwr_reg = reg_wdata;
    end
    if (reg_wr && reg_addr == `ABK_ADDR_DLY) begin
      st_next.dly_reg = reg_wdata[`ABK_DLY_MSB:`ABK_DLY_LSB];
    end
    st_next.rdata_reg = 16'h0000;
    if (reg_rd && reg_addr == `ABK_ADDR_PWR) begin
      st_next.rdata_reg = st_reg.pwr_reg;
    end else if (reg_rd && reg_addr == `ABK_ADDR_DLY) begin
      st_next.rdata_reg = {11'h000, st_reg.dly_reg, 1'b0};
    end
    // Signed step count to magnitude in 10 ps units
    dly_w = st_next.dly_reg;
    abs_w = dly_w[3] ? 4'(-dly_w) : 4'(dly_w);
    st_next.neg_reg = dly_w[3];
    st_next.mag_reg = 8'(abs_w * 8'(`ABK_STEP_PS / 10));
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign reg_rdata = st_reg.rdata_reg;
  assign digital_off = st_reg.pwr_reg[`ABK_DIG_LSB +: 4];
  assign line_off = st_reg.pwr_reg[`ABK_LINE_LSB +: 4];
  assign analog_off = st_reg.pwr_reg[`ABK_ANA_LSB +: 4];
  assign bitclock_skew_setting = st_reg.dly_reg;
  // Magnitude in units of 10 ps
  assign bitclock_skew_ps_mag = st_reg.mag_reg;
  assign bitclock_skew_neg = st_reg.neg_reg;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      abk_lane u_lane (
        .core_clk(core_clk),
        .srst(srst),
        .sample(sample_in[g*14 +: 14]),
        .pattern_on(pattern_on[g]),
        .flip(st_reg.pwr_reg[`ABK_INV_LSB + g]),
        .line_off(line_off[g]),
        .lane_data(lane_out[g*14 +: 14])
      );
    end
  endgenerate
  a_pwr_write: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && reg_addr == 8'h3C |=> digital_off == $past(reg_wdata[15:12])
    && analog_off == $past(reg_wdata[7:4])) else $error("power bits wrong");
  a_line_write: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && reg_addr == 8'h3C |=> line_off == $past(reg_wdata[11:8])) else $error("line bits wrong");
  a_ana_hold: assert property (@(posedge core_clk) disable iff (srst)
    !(reg_wr && reg_addr == 8'h3C) |=> $stable(analog_off)) else $error("analog changed");
  a_inv_data: assert property (@(posedge core_clk) disable iff (srst)
    st_reg.pwr_reg[0] && !pattern_on[0] && !line_off[0] |=> lane_out[13:0] == ~$past(sample_in[13:0]))
    else $error("no inversion");
  a_dly_field: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && reg_addr == 8'h43 |=> bitclock_skew_setting == $past(reg_wdata[4:1])) else $error("skew wrong");
  a_dly_sign: assert property (@(posedge core_clk) disable iff (srst)
    bitclock_skew_setting == 4'hE |-> bitclock_skew_neg && bitclock_skew_ps_mag == 8'h16)
    else $error("sign wrong");
  a_reset_zero: assert property (@(posedge core_clk)
    srst |=> reg_rdata == 16'h0000 && digital_off == 4'h0 && bitclock_skew_setting == 4'h0)
    else $error("reset value");
  a_read_back: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == 8'h43 |=> reg_rdata[15:5] == 11'h000 && reg_rdata[0] == 1'b0)
    else $error("reserved nonzero");

  // Register port requests
  sequence s_pwr_write;
    reg_wr && reg_addr == `ABK_ADDR_PWR;
  endsequence
  sequence s_dly_write;
    reg_wr && reg_addr == `ABK_ADDR_DLY;
  endsequence
  sequence s_pwr_read;
    reg_rd && reg_addr == `ABK_ADDR_PWR;
  endsequence
  sequence s_dly_read;
    reg_rd && reg_addr == `ABK_ADDR_DLY;
  endsequence

  // Controls hold between writes
  a_dig_hold: assert property (@(posedge core_clk) disable iff (srst)
    !(reg_wr && reg_addr == `ABK_ADDR_PWR)
    |=> $stable(digital_off))
    else $error("digital changed");
  a_lane_hold: assert property (@(posedge core_clk) disable iff (srst)
    !(reg_wr && reg_addr == `ABK_ADDR_PWR)
    |=> $stable(line_off))
    else $error("line changed");
  a_skew_hold: assert property (@(posedge core_clk) disable iff (srst)
    !(reg_wr && reg_addr == `ABK_ADDR_DLY)
    |=> $stable(bitclock_skew_setting))
    else $error("skew changed");

  // Read data reflects the control outputs; idle and unmapped reads return zero
  a_pwr_readback: assert property (@(posedge core_clk) disable iff (srst)
    s_pwr_read
    |=> reg_rdata[15:12] == $past(digital_off)
    && reg_rdata[11:8] == $past(line_off)
    && reg_rdata[7:4] == $past(analog_off))
    else $error("power readback wrong");
  a_dly_readback: assert property (@(posedge core_clk) disable iff (srst)
    s_dly_read
    |=> reg_rdata[4:1] == $past(bitclock_skew_setting))
    else $error("skew readback wrong");
  a_pwr_roundtrip: assert property (@(posedge core_clk) disable iff (srst)
    s_pwr_write ##1 s_pwr_read
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("power roundtrip wrong");
  a_dly_roundtrip: assert property (@(posedge core_clk) disable iff (srst)
    s_dly_write ##1 s_dly_read
    |=> reg_rdata == {11'h000, $past(reg_wdata[4:1], 2), 1'h0})
    else $error("skew roundtrip wrong");
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (srst)
    !reg_rd
    |=> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_unmapped_read: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr != `ABK_ADDR_PWR && reg_addr != `ABK_ADDR_DLY
    |=> reg_rdata == 16'h0000)
    else $error("unmapped read nonzero");

  // Signed step decoding
  a_skew_sign: assert property (@(posedge core_clk) disable iff (srst)
    bitclock_skew_neg == bitclock_skew_setting[3])
    else $error("sign mismatch");
  a_skew_none: assert property (@(posedge core_clk) disable iff (srst)
    bitclock_skew_setting == 4'h0
    |-> !bitclock_skew_neg && bitclock_skew_ps_mag == 8'h00)
    else $error("zero skew wrong");
  a_skew_pos_one: assert property (@(posedge core_clk) disable iff (srst)
    bitclock_skew_setting == 4'h1
    |-> !bitclock_skew_neg && bitclock_skew_ps_mag == 8'h0B)
    else $error("plus one step wrong");
  a_skew_neg_one: assert property (@(posedge core_clk) disable iff (srst)
    bitclock_skew_setting == 4'hF
    |-> bitclock_skew_neg && bitclock_skew_ps_mag == 8'h0B)
    else $error("minus one step wrong");

  // Everything idle after reset
  a_reset_all: assert property (@(posedge core_clk)
    srst
    |=> lane_out == 56'h0 && line_off == 4'h0 && analog_off == 4'h0
    && bitclock_skew_ps_mag == 8'h00 && !bitclock_skew_neg)
    else $error("reset outputs");

  // Per line data path
  for (g = 0; g < 4; g++) begin : g_lane_chk
    a_lane_off: assert property (@(posedge core_clk) disable iff (srst)
      line_off[g]
      |=> lane_out[g*14 +: 14] == 14'h0000)
      else $error("line not off");
    a_lane_plain: assert property (@(posedge core_clk) disable iff (srst)
      !st_reg.pwr_reg[`ABK_INV_LSB + g] && !line_off[g]
      |=> lane_out[g*14 +: 14] == $past(sample_in[g*14 +: 14]))
      else $error("plain data altered");
    a_lane_flip: assert property (@(posedge core_clk) disable iff (srst)
      st_reg.pwr_reg[`ABK_INV_LSB + g] && !pattern_on[g] && !line_off[g]
      |=> lane_out[g*14 +: 14] == ~$past(sample_in[g*14 +: 14]))
      else $error("data not inverted");
    a_lane_pattern: assert property (@(posedge core_clk) disable iff (srst)
      pattern_on[g] && !line_off[g]
      |=> lane_out[g*14 +: 14] == $past(sample_in[g*14 +: 14]))
      else $error("pattern inverted");
  end
endmodule
`default_nettype wire

// ===== design/abk_cfg.svh
`ifndef ABK_CFG_SVH
`define ABK_CFG_SVH
`define ABK_ADDR_PWR 8'h3C
`define ABK_ADDR_DLY 8'h43
`define ABK_PWR_RESET 16'h0000
`define ABK_DLY_RESET 16'h0000
`define ABK_DIG_LSB 12
`define ABK_LINE_LSB 8
`define ABK_ANA_LSB 4
`define ABK_INV_LSB 0
`define ABK_DLY_LSB 1
`define ABK_DLY_MSB 4
`define ABK_STEP_PS 110
`define ABK_SAMPLE_W 14
`endif

// ===== design/abk_pkg.sv
package abk_pkg;
  typedef logic [15:0] abk_word_t;
  typedef logic [3:0] abk_lane_vec_t;
  typedef logic signed [3:0] abk_skew_t;
  typedef logic [13:0] abk_sample_t;
endpackage

// ===== design/abk_lane.sv
`timescale 1ns/1ps
`default_nettype none
`include "abk_cfg.svh"
module abk_lane (
  input wire logic core_clk,
  input wire logic srst,
  input wire abk_pkg::abk_sample_t sample,
  input wire logic pattern_on,
  input wire logic flip,
  input wire logic line_off,
  output logic [13:0] lane_data
);
  import abk_pkg::*;
  typedef struct packed {
    abk_sample_t data_reg;
  } abk_lane_st_t;
  abk_lane_st_t st_reg;
  abk_lane_st_t st_next;
  always_comb begin
    st_next = st_reg;
    if (line_off) begin
      st_next.data_reg = '0;
    end else if (flip && !pattern_on) begin
      st_next.data_reg = ~sample;
    end else begin
      st_next.data_reg = sample;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign lane_data = st_reg.data_reg;
  a_pattern_passes: assert property (@(posedge core_clk) disable iff (srst)
    pattern_on && !line_off |=> lane_data == $past(sample)) else $error("pattern altered");
endmodule
`default_nettype wire

// ===== dv/abk_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "abk_cfg.svh"
module abk_bank_tb;
  import abk_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  abk_word_t reg_wdata = 16'h0000;
  abk_word_t reg_rdata;
  logic [55:0] sample_in = 56'h0;
  logic [55:0] lane_out;
  abk_lane_vec_t pattern_on = 4'h0;
  abk_lane_vec_t digital_off, line_off, analog_off;
  abk_skew_t bitclock_skew_setting;
  logic [7:0] bitclock_skew_ps_mag;
  logic bitclock_skew_neg;
  int errors = 0;
  int n_compared = 0;
  always #20 core_clk = ~core_clk;
  abk_bank dut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_in,
    .pattern_on, .lane_out, .digital_off, .line_off, .analog_off, .bitclock_skew_setting,
    .bitclock_skew_ps_mag, .bitclock_skew_neg);
  task automatic chk(string what, logic [55:0] exp, logic [55:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, abk_word_t d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, abk_word_t exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {40'h0, exp}, {40'h0, reg_rdata});
  endtask
  task automatic t_power();
    wr(`ABK_ADDR_PWR, 16'hA5C0);
    @(posedge core_clk);
    #1 chk("digital_off", 56'hA, {52'h0, digital_off});
    chk("line_off", 56'h5, {52'h0, line_off});
    chk("analog_off", 56'hC, {52'h0, analog_off});
    rd(`ABK_ADDR_PWR, 16'hA5C0);
  endtask
  task automatic t_lanes();
    wr(`ABK_ADDR_PWR, 16'h0805);
    sample_in <= {14'h0FFF, 14'h2AAA, 14'h0123, 14'h3C0F};
    pattern_on <= 4'h4;
    repeat (2) @(posedge core_clk);
    #1 chk("lane_out", {14'h0000, 14'h2AAA, 14'h0123, 14'h03F0}, lane_out);
  endtask
  task automatic t_skew();
    logic [3:0] code[4] = '{4'h0, 4'h1, 4'hE, 4'hF};
    logic [7:0] mag[4] = '{8'h00, 8'h0B, 8'h16, 8'h0B};
    for (int i = 0; i < 4; i++) begin
      wr(`ABK_ADDR_DLY, {11'h0, code[i], 1'b0});
      @(posedge core_clk);
      #1 chk("skew", {52'h0, code[i]}, {52'h0, bitclock_skew_setting});
      chk("skew_mag", {48'h0, mag[i]}, {48'h0, bitclock_skew_ps_mag});
      chk("skew_neg", {55'h0, code[i][3]}, {55'h0, bitclock_skew_neg});
    end
    wr(`ABK_ADDR_DLY, 16'h001E);
    rd(`ABK_ADDR_DLY, 16'h001E);
    rd(8'h40, 16'h0000);
  endtask
  task automatic final_report();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rd(`ABK_ADDR_PWR, `ABK_PWR_RESET);
    rd(`ABK_ADDR_DLY, `ABK_DLY_RESET);
    chk("skew_reset", 56'h0, {52'h0, bitclock_skew_setting});
    t_power();
    t_lanes();
    t_skew();
    final_report();
  end
endmodule
`default_nettype wire
